// ==== src/acc_ctrl.sv ====
// Comparator control block: registers, input selection, edge interrupt
`default_nettype none
module acc_ctrl
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog comparator
  input wire logic cmp_raw_i,
  output logic [2:0] positive_input_select_o,
  output logic [2:0] negative_input_select_o,
  output logic [4:0] ladder_step_select_o,
  output logic ladder_enable_o,
  output logic ladder_ext_reference_o,
  // Result and interrupt
  output logic compare_result_out_o,
  output logic irq_o
);
  acc_bus_st_t bus_st_r;
  acc_bus_st_t bus_st_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] lad_r;
  logic [1:0] mask_r;
  logic [1:0] stat_r;
  logic sync_a_r;
  logic sync_b_r;
  logic sync_c_r;
  logic irq_r;
  logic ack_r;
  logic [31:0] rdat_r;
  acc_analog_t ana_r;
  logic edge_flag;
  logic edge_hit;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] din, input logic [3:0] sel,
      input logic [31:0] wmask);
    logic [31:0] bmask;
    bmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
    return (old & ~bmask) | (din & bmask);
  endfunction

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i & (bus_st_r == ACC_BUS_IDLE);
  wire wr = req & wb_we_i;
  wire hit_ctrl = (wb_adr_i == ACC_CTRL_OFF);
  wire hit_lad = (wb_adr_i == ACC_LAD_OFF);
  wire hit_int = (wb_adr_i == ACC_INT_OFF);
  wire hit_mask = (wb_adr_i == ACC_MASK_OFF);
  wire clr_edge = wr & hit_ctrl & wb_sel_i[2] & wb_dat_i[ACC_CLR_BIT];
  wire [1:0] stat_w1c = (wr & hit_int & wb_sel_i[0]) ? wb_dat_i[1:0] :
    2'h0;

  wire sync_sel = ctrl_r[ACC_SYNC_BIT];
  wire cond_res = sync_sel ? sync_b_r : cmp_raw_i;

  always_comb begin
    bus_st_nxt = bus_st_r;
    case (bus_st_r)
      ACC_BUS_IDLE: begin
        if (req) begin
          bus_st_nxt = ACC_BUS_ACK;
        end
      end
      ACC_BUS_ACK: bus_st_nxt = ACC_BUS_IDLE;
      default: bus_st_nxt = ACC_BUS_IDLE;
    endcase
  end

  // Status bit 0 edge flag, bit 1 result change
  wire [1:0] events = {sync_b_r ^ sync_c_r, edge_hit};
  wire [1:0] stat_nxt = events | (stat_r & ~stat_w1c & {1'b1, ~clr_edge});
  // Request follows the new mask in the same cycle as the status
  wire [1:0] mask_nxt = (wr & hit_mask & wb_sel_i[0]) ? wb_dat_i[1:0] :
    mask_r;

  wire [31:0] ctrl_rd = ctrl_r | ({31'h0, edge_flag} << ACC_EDGE_BIT) |
    ({31'h0, sync_b_r} << ACC_RESULT_BIT);
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
    hit_lad ? lad_r :
    hit_int ? {30'h0, stat_r} :
    hit_mask ? {30'h0, mask_r} : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_st_r <= ACC_BUS_IDLE;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      bus_st_r <= bus_st_nxt;
      ack_r <= req;
      rdat_r <= req ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= ACC_CTRL_RST;
      lad_r <= ACC_LAD_RST;
      mask_r <= ACC_MASK_RST;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i, ACC_CTRL_WMASK);
      end
      if (wr && hit_lad) begin
        lad_r <= merge(lad_r, wb_dat_i, wb_sel_i, ACC_LAD_WMASK);
      end
      if (wr && hit_mask && wb_sel_i[0]) begin
        mask_r <= wb_dat_i[1:0];
      end
    end
  end

  // Sync stage; first flop feeds only the second
  // Reset loads the live level, so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a_r <= cmp_raw_i;
      sync_b_r <= cmp_raw_i;
    end else begin
      sync_a_r <= cmp_raw_i;
      sync_b_r <= sync_a_r;
    end
  end

  // Third flop holds the prior synced level for the change event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_c_r <= cmp_raw_i;
    end else begin
      sync_c_r <= sync_b_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ana_r <= '0;
    end else begin
      ana_r.vp_sel <= ctrl_r[ACC_VP_LSB +: 3];
      ana_r.vm_sel <= ctrl_r[ACC_VM_LSB +: 3];
      ana_r.step <= lad_r[ACC_STEP_LSB +: 5];
      ana_r.ladder_en <= lad_r[ACC_LADEN_BIT];
      ana_r.ladder_ref_ext <= lad_r[ACC_LADREF_BIT];
    end
  end

  // result out pin
  // Unregistered only with the sync bit clear; with it set the pin is driven from the sync_b_r flop
  assign compare_result_out_o = cond_res;

  acc_edge u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(sync_b_r),
    .kind_i(ctrl_r[ACC_EDGE_KIND_SELECT_LSB +: 2]),
    .clear_i(clr_edge),
    .flag_o(edge_flag),
    .hit_o(edge_hit)
  );

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign irq_o = irq_r;
  assign positive_input_select_o = ana_r.vp_sel;
  assign negative_input_select_o = ana_r.vm_sel;
  assign ladder_step_select_o = ana_r.step;
  assign ladder_enable_o = ana_r.ladder_en;
  assign ladder_ext_reference_o = ana_r.ladder_ref_ext;

  ack_one_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  ack_after_req_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("no ack after request");
  ack_state_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> bus_st_r == ACC_BUS_ACK)
    else $error("ack outside answer state");
  idle_data_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  rd_unmapped_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    req && !(hit_ctrl || hit_lad || hit_int || hit_mask) |=>
    wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  wr_unmapped_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    wr && !(hit_ctrl || hit_lad || hit_mask) |=>
    $stable(ctrl_r) && $stable(lad_r) && $stable(mask_r))
    else $error("stray write changed a register");
  ctrl_reserved_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r & ~ACC_CTRL_WMASK) == 32'h0000_0000)
    else $error("control reserved bit set");
  lad_reserved_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    (lad_r & ~ACC_LAD_WMASK) == 32'h0000_0000)
    else $error("ladder reserved bit set");
  ctrl_write_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_ctrl && wb_sel_i == 4'hF |=>
    ctrl_r == ($past(wb_dat_i) & ACC_CTRL_WMASK))
    else $error("control write lost");
  lad_write_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_lad && wb_sel_i == 4'hF |=>
    lad_r == ($past(wb_dat_i) & ACC_LAD_WMASK))
    else $error("ladder write lost");
  ctrl_lane_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_ctrl && wb_sel_i[1:0] == 2'h0 |=> $stable(ctrl_r))
    else $error("control lane mask ignored");
  lad_lane_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_lad && !wb_sel_i[0] |=> $stable(lad_r))
    else $error("ladder lane mask ignored");
  result_bit_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    req && hit_ctrl |=> wb_dat_o[ACC_RESULT_BIT] == $past(sync_b_r))
    else $error("result bit wrong");
  change_sets_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    sync_b_r != sync_c_r |=> stat_r[1])
    else $error("result change not recorded");
  flag_bit_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    req && hit_ctrl |=> wb_dat_o[ACC_EDGE_BIT] == $past(edge_flag))
    else $error("edge flag bit wrong");
  irq_follow_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    edge_hit && mask_r[0] |=> irq_o)
    else $error("edge did not raise request");
  irq_level_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == (|(stat_r & mask_r)))
    else $error("request not equal to unmasked status");
  mask_write_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_mask && wb_sel_i[0] |=> mask_r == $past(wb_dat_i[1:0]))
    else $error("mask write lost");
  flag_clear_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    clr_edge && !edge_hit |=> !stat_r[0])
    else $error("clear left status set");
  int_clear_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_int && wb_sel_i[0] && wb_dat_i[0] && !edge_hit |=> !stat_r[0])
    else $error("status write one left bit set");
  clear_irq_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    clr_edge && !edge_hit && !mask_r[1] |=> !irq_o)
    else $error("clear left request high");
  sync_path_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    sync_sel |-> compare_result_out_o == $past(cmp_raw_i, 2))
    else $error("synced output wrong");
  direct_path_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    !sync_sel |-> compare_result_out_o == cmp_raw_i)
    else $error("direct output wrong");
  vp_select_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 positive_input_select_o == $past(ctrl_r[10:8]))
    else $error("positive select lag");
  vm_select_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 negative_input_select_o == $past(ctrl_r[13:11]))
    else $error("negative select lag");
  step_select_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ladder_step_select_o == $past(lad_r[5:1]))
    else $error("ladder step lag");
  ladder_en_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ladder_enable_o == $past(lad_r[ACC_LADEN_BIT]))
    else $error("ladder power lag");
  ladder_ref_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ladder_ext_reference_o == $past(lad_r[ACC_LADREF_BIT]))
    else $error("ladder reference lag");
  edge_cov_c: cover property (@(posedge clk_i) edge_hit ##1 irq_o);
  clear_cov_c: cover property (@(posedge clk_i) clr_edge);
  sync_cov_c: cover property (@(posedge clk_i) sync_sel && edge_hit);
  mask_cov_c: cover property (@(posedge clk_i) irq_o ##1 !irq_o);
  lad_cov_c: cover property (@(posedge clk_i) wr && hit_lad);
endmodule
`default_nettype wire

// ==== pkg/acc_pkg.sv ====
// Package with register map, fields and types of the comparator control
`default_nettype none
package acc_pkg;
  // Register offsets (byte addresses)
  localparam logic [11:0] ACC_CTRL_OFF = 12'h000;
  localparam logic [11:0] ACC_LAD_OFF = 12'h004;
  localparam logic [11:0] ACC_INT_OFF = 12'h008;
  localparam logic [11:0] ACC_MASK_OFF = 12'h00C;
  // Control register fields
  localparam int ACC_EDGE_KIND_SELECT_LSB = 3;
  localparam int ACC_SYNC_BIT = 6;
  localparam int ACC_VP_LSB = 8;
  localparam int ACC_VM_LSB = 11;
  localparam int ACC_CLR_BIT = 20;
  localparam int ACC_RESULT_BIT = 21;
  localparam int ACC_EDGE_BIT = 23;
  // Ladder register fields
  localparam int ACC_LADEN_BIT = 0;
  localparam int ACC_STEP_LSB = 1;
  localparam int ACC_LADREF_BIT = 6;
  // Reset values
  localparam logic [31:0] ACC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ACC_LAD_RST = 32'h0000_0000;
  localparam logic [1:0] ACC_MASK_RST = 2'h0;
  // Writable bits
  localparam logic [31:0] ACC_CTRL_WMASK = 32'h0000_3F58;
  localparam logic [31:0] ACC_LAD_WMASK = 32'h0000_007F;
  // Edge kinds
  localparam logic [1:0] ACC_EDGE_FALL = 2'h0;
  localparam logic [1:0] ACC_EDGE_RISE = 2'h1;
  // Input source codes
  localparam logic [2:0] ACC_SRC_LADDER = 3'h0;
  localparam logic [2:0] ACC_SRC_IN_ONE = 3'h1;
  localparam logic [2:0] ACC_SRC_IN_TWO = 3'h2;
  localparam logic [2:0] ACC_SRC_BANDGAP = 3'h6;
  // System interrupt line number
  localparam int ACC_IRQ_LINE = 11;

  typedef enum logic [1:0] {
    ACC_BUS_IDLE = 2'b01,
    ACC_BUS_ACK = 2'b10
  } acc_bus_st_t;

  typedef struct packed {
    logic [2:0] vp_sel;
    logic [2:0] vm_sel;
    logic [4:0] step;
    logic ladder_en;
    logic ladder_ref_ext;
  } acc_analog_t;
endpackage
`default_nettype wire

// ==== src/acc_edge.sv ====
// Edge detector with sticky edge flag for the comparator result
`default_nettype none
module acc_edge
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic level_i,
  input wire logic [1:0] kind_i,
  input wire logic clear_i,
  // Status
  output logic flag_o,
  output logic hit_o
);
  logic prev_r;
  logic flag_r;
  wire rise = level_i & ~prev_r;
  wire fall = ~level_i & prev_r;
  wire both = kind_i[1];
  wire hit = both ? (rise | fall) :
    (kind_i == ACC_EDGE_RISE) ? rise : fall;

  always_ff @(posedge clk_i) begin
    // Tracks the level in reset too, so no false edge after it
    prev_r <= level_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else if (hit) begin
      flag_r <= 1'b1;
    end else if (clear_i) begin
      flag_r <= 1'b0;
    end
  end

  assign flag_o = flag_r;
  assign hit_o = hit;

  edge_sets_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    hit |=> flag_r)
    else $error("edge did not set flag");
  edge_clear_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    clear_i && !hit |=> !flag_r)
    else $error("clear did not drop flag");
  fall_only_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    kind_i == ACC_EDGE_FALL && rise |-> !hit)
    else $error("rising edge seen in falling mode");
  edge_once_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
    hit |=> !hit || $changed(level_i))
    else $error("one transition counted twice");
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking testbench for the comparator control block
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  err_total++; $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
  end end
module testbench
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, cmp_raw;
  logic [11:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, rd_dat, q, v, clr;
  logic ack, irq, res_out, lad_en, lad_ext, e, lvl;
  logic [2:0] vp, vm;
  logic [4:0] step;
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h6};
  logic [31:0] seed = 32'hDD87;
  int err_total = 0;
  int tests_run = 0;

  acc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(rd_dat),
    .wb_ack_o(ack), .cmp_raw_i(cmp_raw), .positive_input_select_o(vp),
    .negative_input_select_o(vm), .ladder_step_select_o(step),
    .ladder_enable_o(lad_en), .ladder_ext_reference_o(lad_ext),
    .compare_result_out_o(res_out), .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Both codes 2 and 3 take either direction
  function automatic logic exp_hit(input logic [1:0] k, input logic rise);
    return k[1] | (k[0] == rise);
  endfunction

  // Classic cycle; entered just after a rising edge
  task automatic bus(input logic we, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rd_dat;
    if (n >= 50) `CHK(ack, 1'b1)
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic report_and_stop();
    $display("TB: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Generous bound over the whole sequence
  initial begin
    #(25 * 20000);
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    {wb_cyc, wb_stb, wb_we, cmp_raw} = 4'h0;
    wb_adr = 12'h000;
    wb_sel = 4'hF;
    wb_dat = 32'h0000_0000;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, ACC_CTRL_OFF, 32'h0, 4'hF, q);
    `CHK(q & ~(32'h1 << ACC_RESULT_BIT), ACC_CTRL_RST)
    bus(1'b0, ACC_LAD_OFF, 32'h0, 4'hF, q);
    `CHK(q, ACC_LAD_RST)
    bus(1'b1, 12'h010, 32'hFFFF_FFFF, 4'hF, q);
    bus(1'b0, 12'h010, 32'h0, 4'hF, q);
    `CHK(q, 32'h0)
    $display("TB: register reset test done");
    for (int i = 0; i < 4; i++) begin
      v = rnd() & ACC_LAD_WMASK;
      bus(1'b1, ACC_LAD_OFF, v, 4'hF, q);
      bus(1'b0, ACC_LAD_OFF, 32'h0, 4'hF, q);
      `CHK(q, v)
      `CHK(step, v[ACC_STEP_LSB +: 5])
      `CHK(lad_en, v[ACC_LADEN_BIT])
      `CHK(lad_ext, v[ACC_LADREF_BIT])
    end
    // Second byte lane only: ladder bits must hold
    bus(1'b1, ACC_LAD_OFF, 32'hFFFF_FFFF, 4'h2, q);
    bus(1'b0, ACC_LAD_OFF, 32'h0, 4'hF, q);
    `CHK(q, v)
    $display("TB: ladder test done");
    for (int i = 0; i < 4; i++) begin
      v = (rnd() & ~(32'h3F << ACC_VP_LSB)) | (32'(codes[i]) << ACC_VP_LSB)
        | (32'(codes[3 - i]) << ACC_VM_LSB);
      bus(1'b1, ACC_CTRL_OFF, v, 4'hF, q);
      bus(1'b0, ACC_CTRL_OFF, 32'h0, 4'hF, q);
      `CHK(q & 32'hFF5F_FFFF, v & ACC_CTRL_WMASK)
      `CHK(vp, codes[i])
      `CHK(vm, codes[3 - i])
    end
    $display("TB: selector test done");
    clr = 32'h1 << ACC_CLR_BIT;
    bus(1'b1, ACC_MASK_OFF, 32'h1, 4'hF, q);
    for (int k = 0; k < 4; k++) begin
      for (int d = 0; d < 2; d++) begin
        cmp_raw <= ~d[0];
        repeat (6) @(posedge clk_i);
        bus(1'b1, ACC_CTRL_OFF, (32'(k) << ACC_EDGE_KIND_SELECT_LSB) | clr, 4'hF, q);
        bus(1'b1, ACC_INT_OFF, 32'h3, 4'hF, q);
        cmp_raw <= d[0];
        repeat (6) @(posedge clk_i);
        bus(1'b0, ACC_CTRL_OFF, 32'h0, 4'hF, q);
        e = exp_hit(k[1:0], d[0]);
        `CHK(q[ACC_EDGE_BIT], e)
        `CHK(irq, e)
        bus(1'b1, ACC_CTRL_OFF, (32'(k) << ACC_EDGE_KIND_SELECT_LSB) | clr, 4'hF, q);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0)
        bus(1'b0, ACC_CTRL_OFF, 32'h0, 4'hF, q);
        `CHK(q[ACC_EDGE_BIT], 1'b0)
      end
    end
    $display("TB: edge kind test done");
    bus(1'b1, ACC_MASK_OFF, 32'h0, 4'hF, q);
    cmp_raw <= ~cmp_raw;
    repeat (6) @(posedge clk_i);
    `CHK(irq, 1'b0)
    bus(1'b0, ACC_INT_OFF, 32'h0, 4'hF, q);
    `CHK(q, 32'h3)
    bus(1'b1, ACC_MASK_OFF, 32'h1, 4'hF, q);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b1)
    bus(1'b1, ACC_INT_OFF, 32'h1, 4'hF, q);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    bus(1'b0, ACC_INT_OFF, 32'h0, 4'hF, q);
    `CHK(q, 32'h2)
    $display("TB: mask test done");
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, ACC_CTRL_OFF, 32'(s) << ACC_SYNC_BIT, 4'hF, q);
      lvl = ~cmp_raw;
      cmp_raw <= lvl;
      if (s == 1) begin
        @(posedge clk_i);
        @(negedge clk_i);
        `CHK(res_out, ~lvl)
      end
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK(res_out, lvl)
      @(posedge clk_i);
      bus(1'b0, ACC_CTRL_OFF, 32'h0, 4'hF, q);
      `CHK(q[ACC_RESULT_BIT], lvl)
      // Reread once and check the result bit again
      bus(1'b0, ACC_CTRL_OFF, 32'h0, 4'hF, q);
      `CHK(q[ACC_RESULT_BIT], lvl)
    end
    $display("TB: output path test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
